// File: aec_pkg.sv
// package: register map, field positions and codes of the event counter
// assumes an 8-bit register port with single-cycle strobes
package aec_pkg;
  localparam logic [2:0] ADDR_EDGE_SEL = 3'h0;
  localparam logic [2:0] ADDR_CLK_CTL = 3'h2;
  localparam logic [2:0] ADDR_CTL_STAT = 3'h3;
  localparam logic [2:0] ADDR_CNT_HIGH = 3'h4;
  localparam logic [2:0] ADDR_CNT_LOW = 3'h5;
  localparam logic [7:0] RESET_VAL = 8'h00;
  localparam int FLD_HIGH_EDGE = 6;
  localparam int FLD_LOW_EDGE = 4;
  localparam int FLD_GATE_EDGE = 2;
  localparam int BIT_PWM_EN = 1;
  localparam int FLD_HIGH_CLK = 6;
  localparam int FLD_LOW_CLK = 4;
  localparam int FLD_PWM_CLK = 1;
  localparam int BIT_OVF_HIGH = 7;
  localparam int BIT_OVF_LOW = 6;
  localparam int BIT_SPARE = 5;
  localparam int BIT_CHAN_MODE = 4;
  localparam int BIT_CNT_EN_HIGH = 3;
  localparam int BIT_CNT_EN_LOW = 2;
  localparam int BIT_RUN_HIGH = 1;
  localparam int BIT_RUN_LOW = 0;
  localparam int PRESCALE_W = 6;
  typedef enum logic [1:0] {
    EDGE_FALL = 2'b00,
    EDGE_RISE = 2'b01,
    EDGE_BOTH = 2'b10,
    EDGE_NONE = 2'b11
  } aec_edge_t;
  typedef enum logic [1:0] {
    SRC_PIN = 2'b00,
    SRC_DIV2 = 2'b01,
    SRC_DIV4 = 2'b10,
    SRC_DIV8 = 2'b11
  } aec_src_t;
  typedef struct packed {
    logic [2:0] addr;
    logic [7:0] wdata;
    logic wr;
    logic rd;
  } aec_bus_req_t;
  typedef struct packed {
    logic high_event_pin;
    logic low_event_pin;
    logic gate_interrupt_pin;
    logic pwm_gate_output;
  } aec_pins_t;
endpackage : aec_pkg

// File: aec_edge_det.sv
// synchroniser and edge detector for one asynchronous pin
// assumes the pin may change at any time relative to the clock
`timescale 1ns/10ps
module aec_edge_det (
  input wire logic i_clk_sys,
  input wire logic i_resetn,
  input wire logic i_pin,
  input aec_pkg::aec_edge_t i_mode,
  output logic o_level,
  output logic o_event
);
  import aec_pkg::*;
  logic meta_q;
  logic sync_q;
  logic last_q;
  always_ff @(posedge i_clk_sys or negedge i_resetn) begin
    if (!i_resetn) begin
      meta_q <= 1'b0;
      sync_q <= 1'b0;
      last_q <= 1'b0;
    end else begin
      meta_q <= i_pin;
      sync_q <= meta_q;
      last_q <= sync_q;
    end
  end
  assign o_level = sync_q;
  // prohibited code senses nothing
  always_comb begin
    case (i_mode)
      EDGE_FALL: o_event = last_q & ~sync_q;
      EDGE_RISE: o_event = ~last_q & sync_q;
      EDGE_BOTH: o_event = last_q ^ sync_q;
      default: o_event = 1'b0;
    endcase
  end
endmodule : aec_edge_det

// File: aec_byte_counter.sv
// one 8-bit up-counter with hold-at-zero, enable and wrap pulse
// assumes i_tick is a one-cycle pulse
`timescale 1ns/10ps
module aec_byte_counter #(
  parameter int WIDTH = 8
) (
  input wire logic i_clk_sys,
  input wire logic i_resetn,
  input wire logic i_run,
  input wire logic i_enable,
  input wire logic i_tick,
  output logic [WIDTH-1:0] o_count,
  output logic o_wrap
);
  import aec_pkg::*;
  initial begin
    if (WIDTH < 1) $error("aec_byte_counter: WIDTH must be positive");
  end
  logic [WIDTH-1:0] count_q;
  assign o_wrap = i_run & i_enable & i_tick & (&count_q);
  always_ff @(posedge i_clk_sys or negedge i_resetn) begin
    if (!i_resetn) begin
      count_q <= '0;
    end else if (!i_run) begin
      count_q <= '0;
    end else if (i_enable && i_tick) begin
      count_q <= count_q + 1'b1;
    end
  end
  assign o_count = count_q;
endmodule : aec_byte_counter

// File: aec_ctrl.sv
// top of the event counter: registers, clock sources, gating, flags
// assumes pins asynchronous, register port synchronous to i_clk_sys
//
// Chosen here: the address map and the address-and-strobe port.
`timescale 1ns/10ps
// Notes on behaviour
// (R01) low pin edge select, 11 senses nothing
// (R02) gate pin edge select, 11 senses nothing
// (R03) pwm enable picks pwm gate over pin
// (R04) reserved bit 0 storable, reset zero
// (R05) high counter source: pin or prescaler
// (R06) low counter source: pin or prescaler
// (R07) pwm clock select, top bit coarse
// (R08) high overflow flag set on wrap
// (R09) 16-bit mode: high flag marks 16-bit wrap
// (R10) low overflow flag set on wrap
// (R11) flags clear by 0 after read 1
// (R12) control/status resets to all zero
// (R13) mode 0: low wrap clocks high counter
// (R14) mode 1: two independent 8-bit counters
// (R15) high enable gates high counter events
// (R16) low enable gates low counter events
// (R17) high reset control holds counter zero
// (R18) low reset control holds counter zero
// (R19) bit 5 plain storage bit
// (R20) clocks pass only while gate high
// (R21) wrap continues, raises shared request
// (R22) high pin edge select, 11 senses nothing
// (R23) pins synchronised and edge detected
module aec_ctrl #(
  parameter int CNT_W = 8
) (
  input wire logic i_clk_sys,
  input wire logic i_resetn,
  input aec_pkg::aec_bus_req_t i_bus,
  output logic [7:0] o_rdata,
  input aec_pkg::aec_pins_t i_pins,
  output logic o_gate_event,
  output logic o_pwm_clk_tick,
  output logic o_pwm_run,
  output logic o_overflow_req
);
  import aec_pkg::*;
  initial begin
    if (CNT_W != 8) $error("aec_ctrl: counters are 8 bits wide");
  end
  logic [7:0] edge_select_pwm_enable_q;
  logic [7:0] counter_clock_control_q;
  logic [5:0] ctl_q;
  logic ovf_high_q;
  logic ovf_low_q;
  logic seen_high_q;
  logic seen_low_q;
  logic [PRESCALE_W-1:0] pre_q;
  logic [PRESCALE_W-1:0] pre_d;
  logic [7:0] rdata_q;
  logic [7:0] cnt_high;
  logic [7:0] cnt_low;
  logic wrap_high;
  logic wrap_low;
  logic ev_high;
  logic ev_low;
  logic lvl_gate;
  logic lvl_pwm;
  logic gate_open;
  logic tick_high;
  logic tick_low;
  logic src_high;
  logic src_low;
  logic wr_stat;
  logic rd_stat;
  logic [5:0] div_pulse;

  wire aec_edge_t high_mode = aec_edge_t'(edge_select_pwm_enable_q[FLD_HIGH_EDGE +: 2]);
  wire aec_edge_t low_mode = aec_edge_t'(edge_select_pwm_enable_q[FLD_LOW_EDGE +: 2]);
  wire aec_edge_t gate_mode = aec_edge_t'(edge_select_pwm_enable_q[FLD_GATE_EDGE +: 2]);
  wire pwm_en = edge_select_pwm_enable_q[BIT_PWM_EN];
  wire chan_mode = ctl_q[BIT_CHAN_MODE];

  // (R23) synchronise and edge-detect pins
  // (R22) high pin edge choice
  aec_edge_det u_high (
    .i_clk_sys(i_clk_sys),
    .i_resetn(i_resetn),
    .i_pin(i_pins.high_event_pin),
    .i_mode(high_mode),
    .o_level(),
    .o_event(ev_high)
  );
  // (R01) low pin edge choice
  aec_edge_det u_low (
    .i_clk_sys(i_clk_sys),
    .i_resetn(i_resetn),
    .i_pin(i_pins.low_event_pin),
    .i_mode(low_mode),
    .o_level(),
    .o_event(ev_low)
  );
  // (R02) gate pin edge choice
  aec_edge_det u_gate (
    .i_clk_sys(i_clk_sys),
    .i_resetn(i_resetn),
    .i_pin(i_pins.gate_interrupt_pin),
    .i_mode(gate_mode),
    .o_level(lvl_gate),
    .o_event(o_gate_event)
  );
  aec_edge_det u_pwm (
    .i_clk_sys(i_clk_sys),
    .i_resetn(i_resetn),
    .i_pin(i_pins.pwm_gate_output),
    .i_mode(EDGE_NONE),
    .o_level(lvl_pwm),
    .o_event()
  );

  // free-running prescaler; divide-by-2^k pulse when low k bits all ones
  always_comb begin
    pre_d = pre_q + 1'b1;
  end
  always_ff @(posedge i_clk_sys or negedge i_resetn) begin
    if (!i_resetn) begin
      pre_q <= '0;
    end else begin
      pre_q <= pre_d;
    end
  end
  genvar g;
  generate
    for (g = 0; g < 6; g++) begin : g_div
      assign div_pulse[g] = &pre_q[g:0];
    end
  endgenerate

  // (R07) pwm clock: top bit picks 32 or 64
  always_comb begin
    if (counter_clock_control_q[FLD_PWM_CLK + 2]) begin
      o_pwm_clk_tick = counter_clock_control_q[FLD_PWM_CLK] ? div_pulse[5] : div_pulse[4];
    end else begin
      o_pwm_clk_tick = div_pulse[counter_clock_control_q[FLD_PWM_CLK +: 2]];
    end
  end

  // (R05) high source select
  always_comb begin
    case (aec_src_t'(counter_clock_control_q[FLD_HIGH_CLK +: 2]))
      SRC_PIN: src_high = ev_high;
      SRC_DIV2: src_high = div_pulse[0];
      SRC_DIV4: src_high = div_pulse[1];
      SRC_DIV8: src_high = div_pulse[2];
      default: src_high = 1'b0;
    endcase
  end
  // (R06) low source select
  always_comb begin
    case (aec_src_t'(counter_clock_control_q[FLD_LOW_CLK +: 2]))
      SRC_PIN: src_low = ev_low;
      SRC_DIV2: src_low = div_pulse[0];
      SRC_DIV4: src_low = div_pulse[1];
      SRC_DIV8: src_low = div_pulse[2];
      default: src_low = 1'b0;
    endcase
  end

  // (R03) pwm enable chooses gate source
  assign o_pwm_run = pwm_en;
  // (R20) gate level passes counter clocks
  assign gate_open = pwm_en ? lvl_pwm : lvl_gate;
  assign tick_low = gate_open & src_low;
  // (R13) (R14) high clock: low wrap or own source
  assign tick_high = chan_mode ? (gate_open & src_high) : wrap_low;

  // (R16) (R18) low counter
  aec_byte_counter #(.WIDTH(CNT_W)) u_cnt_low (
    .i_clk_sys(i_clk_sys),
    .i_resetn(i_resetn),
    .i_run(ctl_q[BIT_RUN_LOW]),
    .i_enable(ctl_q[BIT_CNT_EN_LOW]),
    .i_tick(tick_low),
    .o_count(cnt_low),
    .o_wrap(wrap_low)
  );
  // (R15) (R17) high counter
  aec_byte_counter #(.WIDTH(CNT_W)) u_cnt_high (
    .i_clk_sys(i_clk_sys),
    .i_resetn(i_resetn),
    .i_run(ctl_q[BIT_RUN_HIGH]),
    .i_enable(ctl_q[BIT_CNT_EN_HIGH]),
    .i_tick(tick_high),
    .o_count(cnt_high),
    .o_wrap(wrap_high)
  );

  assign wr_stat = i_bus.wr && (i_bus.addr == ADDR_CTL_STAT);
  assign rd_stat = i_bus.rd && (i_bus.addr == ADDR_CTL_STAT);

  // (R04) reserved bit 0 kept as storage
  always_ff @(posedge i_clk_sys or negedge i_resetn) begin
    if (!i_resetn) begin
      edge_select_pwm_enable_q <= RESET_VAL;
      counter_clock_control_q <= RESET_VAL;
    end else if (i_bus.wr) begin
      if (i_bus.addr == ADDR_EDGE_SEL) begin
        edge_select_pwm_enable_q <= i_bus.wdata;
      end
      if (i_bus.addr == ADDR_CLK_CTL) begin
        counter_clock_control_q <= i_bus.wdata;
      end
    end
  end

  // (R12) (R19) control bits, spare bit 5 stored
  always_ff @(posedge i_clk_sys or negedge i_resetn) begin
    if (!i_resetn) begin
      ctl_q <= RESET_VAL[5:0];
    end else if (wr_stat) begin
      ctl_q <= i_bus.wdata[5:0];
    end
  end

  // read-of-one arming for the clear
  always_ff @(posedge i_clk_sys or negedge i_resetn) begin
    if (!i_resetn) begin
      seen_high_q <= 1'b0;
      seen_low_q <= 1'b0;
    end else begin
      if (rd_stat) begin
        seen_high_q <= ovf_high_q;
        seen_low_q <= ovf_low_q;
      end else if (wr_stat) begin
        seen_high_q <= 1'b0;
        seen_low_q <= 1'b0;
      end
    end
  end

  // (R08) (R09) (R10) (R11) flags: wrap sets, armed 0 clears, set wins
  always_ff @(posedge i_clk_sys or negedge i_resetn) begin
    if (!i_resetn) begin
      ovf_high_q <= 1'b0;
      ovf_low_q <= 1'b0;
    end else begin
      if (wrap_high) begin
        ovf_high_q <= 1'b1;
      end else if (wr_stat && seen_high_q && !i_bus.wdata[BIT_OVF_HIGH]) begin
        ovf_high_q <= 1'b0;
      end
      if (wrap_low) begin
        ovf_low_q <= 1'b1;
      end else if (wr_stat && seen_low_q && !i_bus.wdata[BIT_OVF_LOW]) begin
        ovf_low_q <= 1'b0;
      end
    end
  end

  // (R21) shared request pulse on any wrap
  assign o_overflow_req = wrap_high | wrap_low;

  always_ff @(posedge i_clk_sys or negedge i_resetn) begin
    if (!i_resetn) begin
      rdata_q <= 8'h00;
    end else if (i_bus.rd) begin
      case (i_bus.addr)
        ADDR_EDGE_SEL: rdata_q <= edge_select_pwm_enable_q;
        ADDR_CLK_CTL: rdata_q <= counter_clock_control_q;
        ADDR_CTL_STAT: rdata_q <= {ovf_high_q, ovf_low_q, ctl_q};
        ADDR_CNT_HIGH: rdata_q <= cnt_high;
        ADDR_CNT_LOW: rdata_q <= cnt_low;
        default: rdata_q <= 8'h00;
      endcase
    end else begin
      rdata_q <= 8'h00;
    end
  end
  assign o_rdata = rdata_q;

  chk_high_wrap_flag: assert property (@(posedge i_clk_sys) disable iff (!i_resetn)
    wrap_high |=> ovf_high_q) else $error("high flag not set on wrap"); // (R08)
  chk_low_wrap_flag: assert property (@(posedge i_clk_sys) disable iff (!i_resetn)
    wrap_low |=> ovf_low_q && cnt_low == 8'h00) else $error("low wrap wrong"); // (R10)
  chk_flag_no_sw_set: assert property (@(posedge i_clk_sys) disable iff (!i_resetn)
    !ovf_low_q && !wrap_low |=> !ovf_low_q) else $error("low flag set by software"); // (R11)
  chk_high_held_zero: assert property (@(posedge i_clk_sys) disable iff (!i_resetn)
    !ctl_q[BIT_RUN_HIGH] |=> cnt_high == 8'h00) else $error("high not held"); // (R17)
  chk_low_held_zero: assert property (@(posedge i_clk_sys) disable iff (!i_resetn)
    !ctl_q[BIT_RUN_LOW] |=> cnt_low == 8'h00) else $error("low not held"); // (R18)
  chk_low_hold_dis: assert property (@(posedge i_clk_sys) disable iff (!i_resetn)
    ctl_q[BIT_RUN_LOW] && !ctl_q[BIT_CNT_EN_LOW] && !wr_stat |=> $stable(cnt_low))
    else $error("low moved while disabled"); // (R16)
  chk_high_hold_dis: assert property (@(posedge i_clk_sys) disable iff (!i_resetn)
    ctl_q[BIT_RUN_HIGH] && !ctl_q[BIT_CNT_EN_HIGH] && !wr_stat |=> $stable(cnt_high))
    else $error("high moved while disabled"); // (R15)
  chk_gate_closed: assert property (@(posedge i_clk_sys) disable iff (!i_resetn)
    !gate_open |-> !tick_low) else $error("tick passed closed gate"); // (R20)
  chk_cascade_16: assert property (@(posedge i_clk_sys) disable iff (!i_resetn)
    !chan_mode |-> tick_high == wrap_low) else $error("cascade broken"); // (R13)
  // (R13) carry really advances high byte
  chk_cascade_inc: assert property (@(posedge i_clk_sys) disable iff (!i_resetn) // (R13)
    !chan_mode && wrap_low && ctl_q[BIT_RUN_HIGH] && ctl_q[BIT_CNT_EN_HIGH]
    |=> cnt_high == $past(cnt_high) + 8'h01) else $error("carry lost");
  // (R09) 16-bit wrap only from all ones
  chk_wrap_16_full: assert property (@(posedge i_clk_sys) disable iff (!i_resetn) // (R09)
    !chan_mode && wrap_high |-> cnt_low == 8'hFF && cnt_high == 8'hFF)
    else $error("16-bit wrap early");
  // (R14) independent high needs its own gated tick
  chk_indep_gate: assert property (@(posedge i_clk_sys) disable iff (!i_resetn) // (R14)
    chan_mode && !gate_open |-> !tick_high)
    else $error("high ticked with gate closed");
  // (R21) wrap returns to zero
  chk_high_wrap_zero: assert property (@(posedge i_clk_sys) disable iff (!i_resetn) // (R21)
    wrap_high |=> cnt_high == 8'h00)
    else $error("high not zero after wrap");
  // (R21) every wrap raises the request
  chk_req_on_wrap: assert property (@(posedge i_clk_sys) disable iff (!i_resetn) // (R21)
    wrap_low || wrap_high |-> o_overflow_req)
    else $error("request missing on wrap");
  // (R11) armed zero write clears the flag
  chk_flag_clear: assert property (@(posedge i_clk_sys) disable iff (!i_resetn) // (R11)
    ovf_low_q && seen_low_q && wr_stat && !i_bus.wdata[BIT_OVF_LOW] && !wrap_low
    |=> !ovf_low_q) else $error("armed clear ignored");
  // (R11) unarmed flag cannot be cleared
  chk_flag_keep: assert property (@(posedge i_clk_sys) disable iff (!i_resetn) // (R11)
    ovf_low_q && !seen_low_q |=> ovf_low_q)
    else $error("flag cleared without read");
  // (R08) software cannot set high flag
  chk_high_no_sw_set: assert property (@(posedge i_clk_sys) disable iff (!i_resetn) // (R08)
    !ovf_high_q && !wrap_high |=> !ovf_high_q)
    else $error("high flag set without wrap");
  // (R03) pwm gate low blocks counting
  chk_pwm_gate_sel: assert property (@(posedge i_clk_sys) disable iff (!i_resetn) // (R03)
    pwm_en && !lvl_pwm |-> !gate_open)
    else $error("pwm gate ignored");
  // (R19) spare bit stores what was written
  chk_spare_store: assert property (@(posedge i_clk_sys) disable iff (!i_resetn) // (R19)
    wr_stat |=> ctl_q[BIT_SPARE] == $past(i_bus.wdata[BIT_SPARE]))
    else $error("spare bit not stored");
  // (R04) reserved bit 0 stores what was written
  chk_reserved_store: assert property (@(posedge i_clk_sys) disable iff (!i_resetn) // (R04)
    i_bus.wr && i_bus.addr == ADDR_EDGE_SEL
    |=> edge_select_pwm_enable_q[0] == $past(i_bus.wdata[0])) else $error("bit 0 lost");
  // (R06) half-rate source never ticks twice running
  chk_div2_spacing: assert property (@(posedge i_clk_sys) disable iff (!i_resetn) // (R06)
    counter_clock_control_q[FLD_LOW_CLK +: 2] == SRC_DIV2 && src_low && !i_bus.wr
    |=> !src_low) else $error("div2 ticked twice");
  // (R22) prohibited code senses nothing
  chk_high_edge_none: assert property (@(posedge i_clk_sys) disable iff (!i_resetn) // (R22)
    high_mode == EDGE_NONE |-> !ev_high)
    else $error("high event on prohibited code");
  // (R16) enabled tick advances low counter
  chk_low_advance: assert property (@(posedge i_clk_sys) disable iff (!i_resetn) // (R16)
    ctl_q[BIT_RUN_LOW] && ctl_q[BIT_CNT_EN_LOW] && tick_low && !wr_stat
    |=> cnt_low == $past(cnt_low) + 8'h01) else $error("low tick lost");
endmodule : aec_ctrl

// File: aec_pin_model.sv
// behavioural model of the pins around the event counter
// assumes the bench calls its tasks; pins change off the clock edges
`timescale 1ns/10ps
module aec_pin_model (
  output aec_pkg::aec_pins_t o_pins
);
  import aec_pkg::*;
  // mask order: high, low, gate, pwm gate
  initial o_pins = '0;
  // offset keeps pin changes away from the sampling edge
  task automatic toggle(input logic [3:0] m, input int n, input int gap);
    #13;
    repeat (n) begin
      o_pins = o_pins ^ m;
      #(gap);
    end
  endtask : toggle
  task automatic set(input logic [3:0] m, input logic v);
    o_pins = v ? (o_pins | m) : (o_pins & ~m);
  endtask : set
endmodule : aec_pin_model

// File: aec_ctrl_tb.sv
// self-checking bench of the event counter top
// assumes the pin model above and the single-cycle register port
`timescale 1ns/10ps
module aec_ctrl_tb;
  import aec_pkg::*;
  logic i_clk_sys = 1'b0;
  logic i_resetn = 1'b0;
  aec_bus_req_t i_bus = '0;
  aec_pins_t i_pins;
  logic [7:0] o_rdata;
  logic o_gate_event, o_pwm_clk_tick, o_pwm_run, o_overflow_req;
  int n_errors = 0;
  int checks_done = 0;
  int n_tick = 0;
  int n_gev = 0;
  int n_ovf = 0;
  logic [7:0] v;
  always #25 i_clk_sys = ~i_clk_sys;
  aec_ctrl aec_ctrl_inst (.i_clk_sys(i_clk_sys), .i_resetn(i_resetn), .i_bus(i_bus),
    .o_rdata(o_rdata), .i_pins(i_pins), .o_gate_event(o_gate_event),
    .o_pwm_clk_tick(o_pwm_clk_tick), .o_pwm_run(o_pwm_run), .o_overflow_req(o_overflow_req));
  aec_pin_model aec_pin_model_inst (.o_pins(i_pins));
  always @(posedge i_clk_sys) begin
    if (o_pwm_clk_tick === 1'b1) n_tick++;
    if (o_gate_event === 1'b1) n_gev++;
    if (o_overflow_req === 1'b1) n_ovf++;
  end
  task automatic chk(input logic [7:0] g, input logic [7:0] lo, input logic [7:0] hi);
    checks_done++;
    if ((g >= lo && g <= hi) !== 1'b1) begin
      n_errors++;
      $display("BAD t=%0t got %h want %h..%h", $time, g, lo, hi);
    end
  endtask : chk
  task automatic wr(input logic [2:0] a, input logic [7:0] d);
    i_bus <= '{addr: a, wdata: d, wr: 1'b1, rd: 1'b0};
    @(posedge i_clk_sys);
    i_bus <= '0;
    // idle edge so the next call never reassigns in this step
    @(posedge i_clk_sys);
  endtask : wr
  task automatic rc(input logic [2:0] a, input logic [7:0] lo, input logic [7:0] hi);
    i_bus <= '{addr: a, wdata: 8'h00, wr: 1'b0, rd: 1'b1};
    @(posedge i_clk_sys);
    i_bus <= '0;
    #1 v = o_rdata;
    @(posedge i_clk_sys);
    chk(v, lo, hi);
  endtask : rc
  task automatic cyc(input int n);
    repeat (n) @(posedge i_clk_sys);
  endtask : cyc
  task automatic t_regs();
    logic [2:0] a[6] = '{3'h0, 3'h2, 3'h3, 3'h4, 3'h5, 3'h7};
    foreach (a[k]) rc(a[k], 8'h00, 8'h00);
    wr(ADDR_EDGE_SEL, 8'h94);
    rc(ADDR_EDGE_SEL, 8'h94, 8'h94);
    wr(ADDR_CLK_CTL, 8'hE4);
    rc(ADDR_CLK_CTL, 8'hE4, 8'hE4);
    wr(ADDR_CTL_STAT, 8'hE0);
    rc(ADDR_CTL_STAT, 8'h20, 8'h20);
    wr(ADDR_CNT_HIGH, 8'h55);
    wr(3'h7, 8'hFE);
    rc(ADDR_CNT_HIGH, 8'h00, 8'h00);
    rc(3'h7, 8'h00, 8'h00);
  endtask : t_regs
  task automatic t_edges();
    int e[4] = '{1, 1, 2, 0};
    wr(ADDR_CLK_CTL, 8'h00);
    aec_pin_model_inst.set(4'h2, 1'b1);
    for (int c = 0; c < 4; c++) begin
      wr(ADDR_EDGE_SEL, {c[1:0], c[1:0], c[1:0], 2'b00});
      wr(ADDR_CTL_STAT, 8'h10);
      wr(ADDR_CTL_STAT, 8'h1F);
      aec_pin_model_inst.toggle(4'hC, 2, 200);
      cyc(6);
      rc(ADDR_CNT_HIGH, e[c][7:0], e[c][7:0]);
      rc(ADDR_CNT_LOW, e[c][7:0], e[c][7:0]);
      n_gev = 0;
      aec_pin_model_inst.toggle(4'h2, 2, 200);
      cyc(6);
      chk(n_gev[7:0], e[c][7:0], e[c][7:0]);
    end
  endtask : t_edges
  task automatic t_presc();
    for (int s = 1; s < 4; s++) begin
      wr(ADDR_CLK_CTL, {s[1:0], s[1:0], 4'h0});
      wr(ADDR_CTL_STAT, 8'h10);
      wr(ADDR_CTL_STAT, 8'h1F);
      cyc(63);
      wr(ADDR_CTL_STAT, 8'h13);
      cyc(20);
      rc(ADDR_CNT_HIGH, (64 >> s) - 2, (64 >> s) + 2);
      rc(ADDR_CNT_LOW, (64 >> s) - 2, (64 >> s) + 2);
      wr(ADDR_CTL_STAT, 8'h1C);
      cyc(10);
      rc(ADDR_CNT_HIGH, 8'h00, 8'h00);
      rc(ADDR_CNT_LOW, 8'h00, 8'h00);
    end
  endtask : t_presc
  task automatic t_gate();
    wr(ADDR_CLK_CTL, 8'h10);
    // close the gate before releasing the counter
    aec_pin_model_inst.set(4'h2, 1'b0);
    cyc(4);
    wr(ADDR_CTL_STAT, 8'h1F);
    cyc(40);
    rc(ADDR_CNT_LOW, 8'h00, 8'h00);
    wr(ADDR_EDGE_SEL, 8'h02);
    aec_pin_model_inst.set(4'h2, 1'b1);
    cyc(40);
    chk({7'h00, o_pwm_run}, 8'h01, 8'h01);
    rc(ADDR_CNT_LOW, 8'h00, 8'h00);
    aec_pin_model_inst.set(4'h1, 1'b1);
    cyc(40);
    wr(ADDR_CTL_STAT, 8'h13);
    rc(ADDR_CNT_LOW, 8'd18, 8'd22);
    wr(ADDR_EDGE_SEL, 8'h00);
    aec_pin_model_inst.set(4'h1, 1'b0);
    cyc(1);
    chk({7'h00, o_pwm_run}, 8'h00, 8'h00);
  endtask : t_gate
  task automatic t_pwmclk();
    int d[8] = '{2, 4, 8, 16, 32, 64, 32, 64};
    for (int c = 0; c < 8; c++) begin
      wr(ADDR_CLK_CTL, {4'h0, c[2:0], 1'b0});
      cyc(2);
      n_tick = 0;
      cyc(128);
      chk(n_tick[7:0], (128 / d[c]) - 1, (128 / d[c]) + 1);
    end
  endtask : t_pwmclk
  task automatic t_ovf();
    wr(ADDR_EDGE_SEL, 8'hA0);
    wr(ADDR_CLK_CTL, 8'h00);
    wr(ADDR_CTL_STAT, 8'h10);
    wr(ADDR_CTL_STAT, 8'h1F);
    n_ovf = 0;
    aec_pin_model_inst.toggle(4'h4, 256, 50);
    cyc(6);
    rc(ADDR_CNT_LOW, 8'h00, 8'h00);
    rc(ADDR_CNT_HIGH, 8'h00, 8'h00);
    wr(ADDR_CTL_STAT, 8'h5F);
    wr(ADDR_CTL_STAT, 8'h1F);
    rc(ADDR_CTL_STAT, 8'h5F, 8'h5F);
    wr(ADDR_CTL_STAT, 8'h1F);
    rc(ADDR_CTL_STAT, 8'h1F, 8'h1F);
    wr(ADDR_CTL_STAT, 8'h0C);
    wr(ADDR_CTL_STAT, 8'h0F);
    aec_pin_model_inst.toggle(4'h4, 256, 50);
    cyc(6);
    rc(ADDR_CNT_HIGH, 8'h01, 8'h01);
    rc(ADDR_CNT_LOW, 8'h00, 8'h00);
    aec_pin_model_inst.toggle(4'h4, 65280, 50);
    cyc(6);
    rc(ADDR_CNT_HIGH, 8'h00, 8'h00);
    rc(ADDR_CTL_STAT, 8'hCF, 8'hCF);
    chk(n_ovf[7:0], 8'h01, 8'h01);
  endtask : t_ovf
  task automatic finish_test();
    $display("checks %0d errors %0d", checks_done, n_errors);
    if (n_errors == 0 && checks_done > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask : finish_test
  initial begin
    cyc(3);
    i_resetn <= 1'b1;
    cyc(1);
    t_regs();
    t_edges();
    t_presc();
    t_gate();
    t_pwmclk();
    t_ovf();
    finish_test();
  end
  // the long wrap run is about 66k cycles; leave headroom
  initial begin
    #(95000 * 50);
    n_errors++;
    finish_test();
  end
endmodule : aec_ctrl_tb
